// ===== cbs_map.svh
// Addresses, bit positions, reset values and sizes of the core bank
// and flag register block.
// Assumes it is included by its bare name; it holds definitions only.
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH

// Data memory address width and special-function addresses
`define CBS_ADDR_W        7
`define CBS_WIN0_ADDR     7'h00
`define CBS_PTR0_ADDR     7'h01
`define CBS_WIN1_ADDR     7'h02
`define CBS_PTR1_ADDR     7'h03
`define CBS_BANKSEL_ADDR  7'h04
`define CBS_ACCUM_ADDR    7'h05
`define CBS_PCLOW_ADDR    7'h06
`define CBS_TBLPTR_ADDR   7'h07
`define CBS_TBLHI_ADDR    7'h08
`define CBS_FLAG_ADDR     7'h0a
// First general-purpose address; below it lies the special area
`define CBS_SFR_END       7'h40

// Flag register bit positions
`define CBS_F_CARRY       0
`define CBS_F_HALF        1
`define CBS_F_ZERO        2
`define CBS_F_SIGNED      3
`define CBS_F_PDOWN       4
`define CBS_F_WDOG        5

// Reset values
`define CBS_REG_RST       8'h00
`define CBS_FLAG_RST      6'h00
`define CBS_BANK_RST      1'b0

// Program counter and general data memory sizes
`define CBS_PC_W          10
`define CBS_RAM_AW        7
`define CBS_RAM_DEPTH     128

`endif

// ===== cbs_pkg.sv
// Types shared by the core bank and flag register block.
// Assumes cbs_map.svh sits in the same folder.
`default_nettype none

package cbs_pkg;
  `include "cbs_map.svh"

  typedef logic [`CBS_ADDR_W-1:0] cbs_addr_t;

  // One data memory access issued by the instruction core
  typedef struct packed {
    logic      valid;
    logic      write;
    cbs_addr_t addr;
    logic [7:0] wdata;
  } cbs_mem_req_t;

  // Operation class of the current ALU step
  typedef enum logic [2:0] {
    CBS_ALU_NONE, CBS_ALU_ADD, CBS_ALU_SUB, CBS_ALU_LOGIC,
    CBS_ALU_RLC, CBS_ALU_RRC, CBS_ALU_MOVE
  } cbs_alu_op_t;

  typedef struct packed {
    cbs_alu_op_t op;
    logic        use_carry;
    logic [7:0]  opa;
    logic [7:0]  opb;
  } cbs_alu_req_t;

  // One-cycle system events from decoder and watchdog
  typedef struct packed {
    logic wdt_timeout;
    logic watchdog_clear_instr;
    logic sleep;
    logic warm_reset;
  } cbs_sys_evt_t;
endpackage : cbs_pkg

`default_nettype wire

// ===== cbs_ram.sv
// General-purpose data memory of both banks, one port.
// Assumes the caller never reads and writes in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cbs_map.svh"

module cbs_ram
  import cbs_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Access port
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire logic [`CBS_RAM_AW-1:0] addr,
  input  wire logic [7:0]             wdata,
  output logic      [7:0]             rdata
);

  // Array holds no reset; contents are undefined at power-up
  logic [7:0] mem [`CBS_RAM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) mem[addr] <= wdata;
  end

  // Registered read data, held between reads
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rdata <= `CBS_REG_RST;
    else if (rd_en) rdata <= mem[addr];
  end

endmodule : cbs_ram

`default_nettype wire

// ===== cbs_regs.sv
// Bank select, accumulator, program counter low byte, table read and
// flag register logic of a small 8-bit core.
// Assumes one clock, a decoder issuing one-cycle requests and a
// program memory that answers table fetches on pm_rvalid.
`timescale 1ns/100ps
`default_nettype none
`include "cbs_map.svh"

module cbs_regs
  import cbs_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Data memory access
  input  wire cbs_mem_req_t         mem_req,
  output logic      [7:0]           rd_data,
  output logic                      rd_valid,
  // ALU step and accumulator
  input  wire cbs_alu_req_t         alu_req,
  output logic      [7:0]           alu_result_holder,
  // System events and visible state
  input  wire cbs_sys_evt_t         sys_evt,
  output logic      [7:0]           flag_register,
  output logic                      bank_select_bit,
  // Program counter
  input  wire logic [`CBS_PC_W-1:0] pc_current,
  output logic                      pc_jump,
  output logic      [`CBS_PC_W-1:0] pc_jump_target,
  output logic                      pipe_bubble,
  // Table read
  input  wire logic                 tbl_fetch,
  output logic                      pm_rd_en,
  output logic      [`CBS_PC_W-1:0] pm_addr,
  input  wire logic                 pm_rvalid,
  input  wire logic [15:0]          pm_rdata,
  output logic                      tbl_low_valid,
  output logic      [7:0]           tbl_low_data
);

  // Architectural and pipeline state
  logic [7:0]             bank0_indirect_pointer;
  logic [7:0]             bank_indirect_pointer;
  logic [7:0]             table_read_pointer;
  logic [7:0]             table_high_byte_latch;
  logic [5:0]             flags;
  logic [5:0]             next_flags;
  logic [7:0]             sfr_q;
  logic                   rd_from_ram;
  logic [7:0]             ram_q;
  logic [7:0]             sfr_rd_val;

  // Address decode of the current access
  wire logic      is_win0  = mem_req.addr == `CBS_WIN0_ADDR;
  wire logic      is_win1  = mem_req.addr == `CBS_WIN1_ADDR;
  wire logic      indirect = is_win0 | is_win1;
  wire cbs_addr_t eff_addr = is_win0 ? bank0_indirect_pointer[6:0] :
                             is_win1 ? bank_indirect_pointer[6:0] :
                                       mem_req.addr;
  // Only the second window adds the bank; direct stays in bank 0
  wire logic eff_bank = is_win1 & bank_select_bit;
  wire logic eff_sfr  = eff_addr < `CBS_SFR_END;
  // A pointer aimed at a window would loop; it is cut off instead
  wire logic eff_win  = indirect & ((eff_addr == `CBS_WIN0_ADDR) |
                                    (eff_addr == `CBS_WIN1_ADDR));
  wire logic access_ok = mem_req.valid & ~eff_win;
  wire logic ram_wr    = access_ok & mem_req.write & ~eff_sfr;
  wire logic ram_rd    = access_ok & ~mem_req.write & ~eff_sfr;
  wire logic sfr_wr    = access_ok & mem_req.write & eff_sfr;
  wire logic [`CBS_RAM_AW-1:0] ram_addr = {eff_bank, eff_addr[5:0]};

  // Per-register write strobes
  wire logic wr_ptr0 = sfr_wr & (eff_addr == `CBS_PTR0_ADDR);
  wire logic wr_ptr1 = sfr_wr & (eff_addr == `CBS_PTR1_ADDR);
  wire logic wr_bank = sfr_wr & (eff_addr == `CBS_BANKSEL_ADDR);
  wire logic wr_accu = sfr_wr & (eff_addr == `CBS_ACCUM_ADDR);
  wire logic wr_pcl  = sfr_wr & (eff_addr == `CBS_PCLOW_ADDR);
  wire logic wr_tptr = sfr_wr & (eff_addr == `CBS_TBLPTR_ADDR);
  wire logic wr_flag = sfr_wr & (eff_addr == `CBS_FLAG_ADDR);

  // Read-back views
  wire logic [7:0] bank_select_pointer = {7'h00, bank_select_bit};
  wire logic [7:0] program_counter_low_byte = pc_current[7:0];
  assign flag_register = {2'b00, flags};

  // Special-function read selection; unmapped reads give zero
  assign sfr_rd_val =
    eff_win                          ? 8'h00 :
    (eff_addr == `CBS_PTR0_ADDR)     ? bank0_indirect_pointer :
    (eff_addr == `CBS_PTR1_ADDR)     ? bank_indirect_pointer :
    (eff_addr == `CBS_BANKSEL_ADDR)  ? bank_select_pointer :
    (eff_addr == `CBS_ACCUM_ADDR)    ? alu_result_holder :
    (eff_addr == `CBS_PCLOW_ADDR)    ? program_counter_low_byte :
    (eff_addr == `CBS_TBLPTR_ADDR)   ? table_read_pointer :
    (eff_addr == `CBS_TBLHI_ADDR)    ? table_high_byte_latch :
    (eff_addr == `CBS_FLAG_ADDR)     ? flag_register : 8'h00;

  // Adder shared by add and subtract; subtract adds the complement
  wire logic is_add = alu_req.op == CBS_ALU_ADD;
  wire logic is_sub = alu_req.op == CBS_ALU_SUB;
  wire logic is_rlc = alu_req.op == CBS_ALU_RLC;
  wire logic is_rrc = alu_req.op == CBS_ALU_RRC;
  wire logic arith  = is_add | is_sub;
  wire logic c_now  = flags[`CBS_F_CARRY];
  wire logic [7:0] opb_eff = is_sub ? ~alu_req.opb : alu_req.opb;
  wire logic cin = alu_req.use_carry ? c_now : is_sub;
  wire logic [4:0] sum_lo = {1'b0, alu_req.opa[3:0]} +
                            {1'b0, opb_eff[3:0]} + {4'h0, cin};
  wire logic [7:0] sum_7  = {1'b0, alu_req.opa[6:0]} +
                            {1'b0, opb_eff[6:0]} + {7'h00, cin};
  wire logic [8:0] sum_8  = {1'b0, alu_req.opa} +
                            {1'b0, opb_eff} + {8'h00, cin};
  wire logic [7:0] alu_res =
    arith  ? sum_8[7:0] :
    is_rlc ? {alu_req.opa[6:0], c_now} :
    is_rrc ? {c_now, alu_req.opa[7:1]} : alu_req.opa;
  wire logic alu_go = alu_req.op != CBS_ALU_NONE;

  // Flag update: ALU beats a same-cycle software write
  wire logic [3:0] sw_arith = wr_flag ? mem_req.wdata[3:0] : flags[3:0];
  always_comb begin
    next_flags = flags;
    next_flags[3:0] = sw_arith;
    if (arith) begin
      next_flags[`CBS_F_CARRY]  = sum_8[8];
      next_flags[`CBS_F_HALF]   = sum_lo[4];
      next_flags[`CBS_F_SIGNED] = sum_7[7] ^ sum_8[8];
    end else if (is_rlc) begin
      next_flags[`CBS_F_CARRY]  = alu_req.opa[7];
    end else if (is_rrc) begin
      next_flags[`CBS_F_CARRY]  = alu_req.opa[0];
    end
    if (arith || alu_req.op == CBS_ALU_LOGIC) begin
      next_flags[`CBS_F_ZERO] = alu_res == 8'h00;
    end
    // Time-out set wins over a clearing instruction in the same cycle
    if (sys_evt.wdt_timeout) begin
      next_flags[`CBS_F_WDOG] = 1'b1;
    end else if (sys_evt.watchdog_clear_instr || sys_evt.sleep) begin
      next_flags[`CBS_F_WDOG] = 1'b0;
    end
    if (sys_evt.sleep) begin
      next_flags[`CBS_F_PDOWN] = 1'b1;
    end else if (sys_evt.watchdog_clear_instr) begin
      next_flags[`CBS_F_PDOWN] = 1'b0;
    end
  end

  // Flags; of the two resets only power-up clears the system flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) flags <= `CBS_FLAG_RST;
    else flags <= next_flags;
  end

  // Bank survives a watchdog wake from power-down, nothing else
  wire logic keep_bank = sys_evt.wdt_timeout & flags[`CBS_F_PDOWN];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select_bit <= `CBS_BANK_RST;
    end else if (sys_evt.warm_reset) begin
      if (!keep_bank) bank_select_bit <= `CBS_BANK_RST;
    end else if (wr_bank) begin
      bank_select_bit <= mem_req.wdata[0];
    end
  end

  // Pointers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank0_indirect_pointer <= `CBS_REG_RST;
      bank_indirect_pointer  <= `CBS_REG_RST;
      table_read_pointer     <= `CBS_REG_RST;
    end else begin
      if (wr_ptr0) bank0_indirect_pointer <= mem_req.wdata;
      if (wr_ptr1) bank_indirect_pointer  <= mem_req.wdata;
      if (wr_tptr) table_read_pointer     <= mem_req.wdata;
    end
  end

  // Every ALU result lands here; moves pass through it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) alu_result_holder <= `CBS_REG_RST;
    else if (alu_go) alu_result_holder <= alu_res;
    else if (wr_accu) alu_result_holder <= mem_req.wdata;
  end

  // Low byte jump keeps the page; the bubble flushes the fetched word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_jump        <= 1'b0;
      pipe_bubble    <= 1'b0;
      pc_jump_target <= '0;
    end else begin
      pc_jump     <= wr_pcl;
      pipe_bubble <= wr_pcl;
      if (wr_pcl) begin
        pc_jump_target <= {pc_current[`CBS_PC_W-1:8], mem_req.wdata};
      end
    end
  end

  // Table fetch in the current page; high byte kept, low byte handed on
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_rd_en              <= 1'b0;
      pm_addr               <= '0;
      tbl_low_valid         <= 1'b0;
      tbl_low_data          <= `CBS_REG_RST;
      table_high_byte_latch <= `CBS_REG_RST;
    end else begin
      pm_rd_en      <= tbl_fetch;
      tbl_low_valid <= pm_rvalid;
      if (tbl_fetch) begin
        pm_addr <= {pc_current[`CBS_PC_W-1:8], table_read_pointer};
      end
      if (pm_rvalid) begin
        table_high_byte_latch <= pm_rdata[15:8];
        tbl_low_data          <= pm_rdata[7:0];
      end
    end
  end

  // Read pipeline: one cycle for both areas
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid    <= 1'b0;
      rd_from_ram <= 1'b0;
      sfr_q       <= `CBS_REG_RST;
    end else begin
      rd_valid    <= mem_req.valid & ~mem_req.write;
      rd_from_ram <= ram_rd;
      sfr_q       <= sfr_rd_val;
    end
  end

  // Both sources are registered, so the choice adds no path from inputs
  assign rd_data = rd_from_ram ? ram_q : sfr_q;

  cbs_ram u_ram (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (ram_wr),
    .rd_en    (ram_rd),
    .addr     (ram_addr),
    .wdata    (mem_req.wdata),
    .rdata    (ram_q)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_bank_upper_zero;
    mem_req.valid && !mem_req.write && !indirect
      && mem_req.addr == `CBS_BANKSEL_ADDR |=> rd_data[7:1] == 7'h00;
  endproperty
  a_bank_upper_zero: assert property (p_bank_upper_zero)
    else $error("bank pointer upper bits not zero");

  property p_bank_warm;
    sys_evt.warm_reset |=> bank_select_bit ==
      ($past(keep_bank) ? $past(bank_select_bit) : 1'b0);
  endproperty
  a_bank_warm: assert property (p_bank_warm)
    else $error("bank select wrong after warm reset");

  // Only meaningful while bank 1 is selected
  property p_direct_bank0;
    mem_req.valid && !indirect && bank_select_bit
      |-> ram_addr == {1'b0, mem_req.addr[5:0]};
  endproperty
  a_direct_bank0: assert property (p_direct_bank0)
    else $error("direct access left bank 0");

  property p_window_zero;
    mem_req.valid && !mem_req.write && eff_win |=> rd_data == 8'h00;
  endproperty
  a_window_zero: assert property (p_window_zero)
    else $error("window read did not return zero");

  property p_add_to_accum;
    is_add && !alu_req.use_carry |=> alu_result_holder ==
      8'($past(alu_req.opa) + $past(alu_req.opb));
  endproperty
  a_add_to_accum: assert property (p_add_to_accum)
    else $error("sum not in accumulator");

  property p_pcl_jump;
    wr_pcl |=> pc_jump && pipe_bubble && pc_jump_target[7:0] ==
      $past(mem_req.wdata) ##1 !pipe_bubble || $past(wr_pcl);
  endproperty
  a_pcl_jump: assert property (p_pcl_jump)
    else $error("low byte jump or bubble wrong");

  property p_sw_keeps_sys;
    wr_flag && !sys_evt.wdt_timeout && !sys_evt.watchdog_clear_instr && !sys_evt.sleep
      |=> flags[5:4] == $past(flags[5:4]);
  endproperty
  a_sw_keeps_sys: assert property (p_sw_keeps_sys)
    else $error("software write changed system flags");

  property p_sleep_flags;
    sys_evt.sleep && !sys_evt.wdt_timeout
      |=> flags[`CBS_F_PDOWN] && !flags[`CBS_F_WDOG];
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep did not set power-down and clear time-out");

  property p_sub_carry;
    is_sub && !alu_req.use_carry |=> flags[`CBS_F_CARRY] ==
      ($past(alu_req.opa) >= $past(alu_req.opb));
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("carry not equal to no-borrow");

endmodule : cbs_regs

`default_nettype wire

// ===== cbs_pm_model.sv
// Program memory model answering table fetches of the flag block.
// Assumes one core clock; lat sets the answer delay in cycles.
`timescale 1ns/100ps
`default_nettype none

module cbs_pm_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Fetch port
  input  wire logic        pm_rd_en,
  input  wire logic [9:0]  pm_addr,
  input  wire logic [3:0]  lat,
  output logic             pm_rvalid,
  output logic      [15:0] pm_rdata
);
  logic [9:0] addr_q;
  logic [3:0] cnt;
  logic       busy;

  // One fetch at a time; data is junk outside the answer cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {busy, cnt, addr_q} <= '0;
      pm_rvalid           <= 1'b0;
      pm_rdata            <= 16'h0000;
    end else begin
      pm_rvalid <= 1'b0;
      pm_rdata  <= pm_rdata + 16'h9e37;  // Never holds old data
      if (pm_rd_en) begin
        {busy, cnt, addr_q} <= {1'b1, lat, pm_addr};
      end else if (busy && cnt == 4'h0) begin
        busy      <= 1'b0;
        pm_rvalid <= 1'b1;
        pm_rdata  <= {addr_q[7:0] + {6'h00, addr_q[9:8]}, ~addr_q[7:0]};
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : cbs_pm_model

`default_nettype wire

// ===== cbs_regs_test.sv
// Self-checking bench for the bank, accumulator and flag block.
// Assumes cbs_pkg, cbs_regs and cbs_pm_model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module cbs_regs_test import cbs_pkg::*;;
  logic         core_clk, rst_n, rd_valid, bank_select_bit, pc_jump;
  logic         pipe_bubble, tbl_fetch, pm_rd_en, pm_rvalid;
  logic         tbl_low_valid;
  logic [7:0]   rd_data, alu_result_holder, flag_register, tbl_low_data;
  logic [9:0]   pc_current, pc_jump_target, pm_addr;
  logic [15:0]  pm_rdata;
  logic [3:0]   lat;
  cbs_mem_req_t mem_req;
  cbs_alu_req_t alu_req;
  cbs_sys_evt_t sys_evt;
  logic [7:0]   rq[$], tq[$];
  logic [7:0]   ea, efl, p;
  int           mismatches, check_count;

  cbs_regs cbs_regs_i (.core_clk, .rst_n, .mem_req, .rd_data, .rd_valid,
    .alu_req, .alu_result_holder, .sys_evt, .flag_register,
    .bank_select_bit, .pc_current, .pc_jump, .pc_jump_target, .pipe_bubble,
    .tbl_fetch, .pm_rd_en, .pm_addr, .pm_rvalid, .pm_rdata, .tbl_low_valid,
    .tbl_low_data);
  cbs_pm_model cbs_pm_model_i (.core_clk, .rst_n, .pm_rd_en, .pm_addr,
    .lat, .pm_rvalid, .pm_rdata);

  // Clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Requests stay up so accesses can run back to back
  task automatic mw(input logic [6:0] a, input logic [7:0] d);
    mem_req = '{1'b1, 1'b1, a, d};
    @(negedge core_clk);
  endtask : mw

  task automatic mr(input logic [6:0] a, input logic [7:0] e);
    mem_req = '{1'b1, 1'b0, a, 8'h00};
    rq.push_back(e);
    @(negedge core_clk);
  endtask : mr

  task automatic rel();
    mem_req = '0;
    @(negedge core_clk);
  endtask : rel

  task automatic evt(input cbs_sys_evt_t e);
    sys_evt = e;
    @(negedge core_clk);
    sys_evt = '0;
    @(negedge core_clk);
    check(flag_register, efl);
  endtask : evt

  // Expected accumulator and flags worked out before driving
  task automatic alu(input cbs_alu_op_t op, input logic uc,
                     input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [7:0] l, bb;
    logic [4:0] h;
    logic       ci;
    bb = (op == CBS_ALU_SUB) ? ~b : b;
    ci = uc ? efl[0] : (op == CBS_ALU_SUB);
    s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    h  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    l  = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
    ea = (op == CBS_ALU_RLC) ? {a[6:0], efl[0]} :
         (op == CBS_ALU_RRC) ? {efl[0], a[7:1]} : a;
    case (op)
      CBS_ALU_ADD, CBS_ALU_SUB: begin
        ea       = s[7:0];
        efl[3:0] = {l[7] ^ s[8], s[7:0] == 8'h00, h[4], s[8]};
      end
      CBS_ALU_LOGIC: efl[2] = (a == 8'h00);
      CBS_ALU_RLC:   efl[0] = a[7];
      CBS_ALU_RRC:   efl[0] = a[0];
      default: ;
    endcase
    alu_req = '{op, uc, a, b};
    @(negedge core_clk);
    alu_req = '0;
    @(negedge core_clk);
    check(alu_result_holder, ea);
    check(flag_register, efl);
  endtask : alu

  // Monitor takes the oldest note as each result appears
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1)
      check(rd_data, rq.size() ? rq.pop_front() : 8'hxx);
    if (tbl_low_valid === 1'b1)
      check(tbl_low_data, tq.size() ? tq.pop_front() : 8'hxx);
  end

  // Main sequence
  initial begin
    mem_req = '0;
    alu_req = '0;
    sys_evt = '0;
    tbl_fetch = 1'b0;
    lat = 4'h0;
    pc_current = 10'h2c5;
    ea = 8'h00;
    efl = 8'h00;
    rst_n = 1'b0;
    void'($urandom(32'hf3b86b80));
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    check(bank_select_bit, 1'b0);
    check({alu_result_holder, flag_register}, 16'h0000);
    mr(7'h0a, 8'h00);
    mr(7'h09, 8'h00);
    mw(7'h04, 8'hff);
    mr(7'h04, 8'h01);
    rel();
    check(bank_select_bit, 1'b1);
    $display("Test bank pointer done");
    // Bank 1 selected: direct goes to bank 0, window 1 to bank 1
    mw(7'h41, 8'haa);
    mw(7'h03, 8'h41);
    mw(7'h02, 8'h55);
    mr(7'h41, 8'haa);
    mr(7'h02, 8'h55);
    mw(7'h01, 8'h41);
    mr(7'h00, 8'haa);
    mr(7'h05, ea);
    mw(7'h03, 8'h02);
    mw(7'h02, 8'h77);
    mr(7'h02, 8'h00);
    mr(7'h03, 8'h02);
    mw(7'h04, 8'h00);
    mw(7'h03, 8'h41);
    mr(7'h02, 8'haa);
    rel();
    $display("Test banks done");
    alu(CBS_ALU_ADD, 1'b0, 8'h80, 8'h80);
    alu(CBS_ALU_SUB, 1'b0, 8'h05, 8'h05);
    alu(CBS_ALU_SUB, 1'b1, 8'h00, 8'h01);
    for (int i = 1; i < 13; i++)
      alu(cbs_alu_op_t'(i % 6 + 1), 1'($urandom), 8'($urandom),
          8'($urandom));
    mr(7'h05, ea);
    mr(7'h0a, efl);
    rel();
    $display("Test arithmetic done");
    // Flag writes leave the system flags alone
    efl[5:4] = 2'b01;
    evt(4'h2);
    mw(7'h0a, 8'hf0);
    mr(7'h0a, 8'h10);
    mw(7'h0a, 8'hff);
    mr(7'h0a, 8'h1f);
    mw(7'h04, 8'h01);
    rel();
    efl = 8'h3f;
    evt(4'h9);
    check(bank_select_bit, 1'b1);
    efl[5] = 1'b0;
    evt(4'h2);
    efl[5] = 1'b1;
    evt(4'h8);
    efl[5:4] = 2'b00;
    evt(4'h4);
    mw(7'h04, 8'h01);
    rel();
    efl[5] = 1'b1;
    evt(4'h9);
    check(bank_select_bit, 1'b0);
    // Set beats clear when both arrive in one cycle
    efl[5:4] = 2'b01;
    evt(4'h6);
    efl[5:4] = 2'b10;
    evt(4'hc);
    efl[5:4] = 2'b01;
    evt(4'h2);
    // Plain warm reset clears the bank even while powered down
    mw(7'h04, 8'h01);
    rel();
    evt(4'h1);
    check(bank_select_bit, 1'b0);
    $display("Test system flags done");
    for (int k = 0; k < 2; k++) begin
      p = 8'($urandom);
      mw(7'h06, p);
      check({pc_jump, pipe_bubble}, 2'b11);
      check(pc_jump_target, {2'b10, p});
      rel();
      check({pc_jump, pipe_bubble}, 2'b00);
    end
    mr(7'h06, 8'hc5);
    rel();
    $display("Test jump done");
    // Prompt then slow answer from program memory
    for (int k = 0; k < 2; k++) begin
      p = 8'($urandom);
      mw(7'h07, p);
      rel();
      lat = k ? 4'h3 : 4'h0;
      tbl_fetch = 1'b1;
      tq.push_back(~p);
      @(negedge core_clk);
      tbl_fetch = 1'b0;
      check(pm_rd_en, 1'b1);
      check(pm_addr, {2'b10, p});
      for (int w = 0; w < 20 && tq.size() > 0; w++) @(negedge core_clk);
      check(tq.size(), 0);
      mr(7'h08, p + 8'h02);
      rel();
    end
    $display("Test table done");
    mw(7'h04, 8'h01);
    rel();
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    check({bank_select_bit, flag_register}, 9'h000);
    $display("Test second reset done");
    finish_test();
  end

  // Cuts a hang short well after the expected run length
  initial begin
    repeat (3000) @(posedge core_clk);
    $display("ERROR at %0t: run did not finish", $time);
    mismatches++;
    finish_test();
  end
endmodule : cbs_regs_test

`default_nettype wire
